// File: hdl/qsms_pkg.sv
// Constants, types and the length decoder for the queued serial port.
// Assumes a single system clock; no register bus, every control is a port.

package qsms_pkg;

    // ------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------
    localparam int PTR_W = 4;
    localparam int WORD_W = 16;
    localparam int PCS_W = 4;
    typedef logic [PTR_W-1:0] qsms_ptr_t;
    typedef logic [WORD_W-1:0] qsms_word_t;
    typedef logic [PCS_W-1:0] qsms_pcs_t;

    // ------------------------------------------------------------
    // Lengths, divisor limit and delays in system clocks
    // ------------------------------------------------------------
    localparam logic [4:0] LEN_DEFAULT = 5'h08;
    localparam logic [4:0] LEN_MAX = 5'h10;
    localparam logic [7:0] BAUD_MIN = 8'h02;
    localparam logic [13:0] STD_DELAY_CYC = 14'h0011;
    localparam logic [13:0] ONE_CYC = 14'h0001;
    localparam logic [4:0] DT_SCALE_SHIFT = 5'h05;

    // ------------------------------------------------------------
    // Master sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {M_IDLE, M_LOAD, M_LEAD, M_SHIFT, M_TRAIL} qsms_state_e;

    // Code zero is 16 bits; reserved low codes fall back to 16 as well.
    function automatic logic [4:0] qsms_len(input logic [3:0] code);
        qsms_len = code[3] ? {2'b01, code[2:0]} : LEN_MAX;
    endfunction : qsms_len

endpackage : qsms_pkg

// File: hdl/qsms_top.sv
// Queued synchronous serial port, master and slave, one system clock.
// Assumes queue storage outside: entry fields arrive for QUEUE_INDEX in
// the same cycle, and received words leave through a two-entry buffer.
//
// Overview of operation
// - Master ignores slave select; select low flags fault.
// - Master clock is system clock over twice divisor.
// - Divisor zero or one stops the serial clock.
// - Clock delay bit: lead time equals delay count.
// - Clock delay clear: lead time is half period.
// - Length select picks eight bits or length field.
// - Delay select: trail lasts thirty-two times count.
// - Trail count zero gives 8192 clocks.
// - Delay select clear: trail lasts 17 clocks.
// - Enable starts entry at new-queue pointer.
// - Each transfer copies pointer to completed, increments.
// - Continue holds pattern, else pin data between transfers.
// - Queue end sets flag, interrupt, stops without wrap.
// - Wrap restarts at zero or new-queue pointer.
// - Wrap keeps running, enable stays, flag stays set.
// - Interrupt enable buffered; software clears the flag.
// - Wrap cleared: stop at the next queue end.
// - Halt finishes current transfer, then stops.
// - Slave starts at new-queue pointer when enabled.
// - Slave ignores commands, divisor, delays; drives no clock.
// - Slave uses length field, steps pointers per word.
// - Early select rise restarts same entry from its first bit next time.
// - Pointers reset to zero; single transfer by default.
// - Queue end found comparing queue index and end pointers.

`timescale 1ns/100ps
`default_nettype none

module qsms_top #(
    parameter logic [13:0] DT_ZERO_CYCLES = 14'h2000
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic MASTER_SELECT_BIT,
    input wire logic PORT_ENABLE_SET,
    input wire logic PORT_ENABLE_CLR,
    output logic PORT_ENABLE_BIT,
    input wire logic CLOCK_PHASE_BIT,
    input wire logic CLOCK_POLARITY_BIT,
    input wire logic [7:0] BAUD_DIVISOR,
    input wire logic [6:0] CLOCK_DELAY_COUNT,
    input wire logic [7:0] AFTER_TRANSFER_DELAY_COUNT,
    input wire logic [3:0] LENGTH_FIELD,
    input wire logic WRAP_ENABLE_BIT,
    input wire logic WRAP_TARGET_BIT,
    input wire logic HALT_BIT,
    output logic HALTED,
    input wire logic NEW_QUEUE_WR,
    input wire qsms_pkg::qsms_ptr_t NEW_QUEUE_POINTER,
    input wire qsms_pkg::qsms_ptr_t END_QUEUE_POINTER,
    output qsms_pkg::qsms_ptr_t QUEUE_INDEX,
    output qsms_pkg::qsms_ptr_t COMPLETED_POINTER,
    input wire qsms_pkg::qsms_pcs_t CMD_CHIP_SELECTS,
    input wire logic CMD_CONTINUE_BIT,
    input wire logic CMD_LENGTH_SELECT_BIT,
    input wire logic CMD_DELAY_SELECT_BIT,
    input wire logic CMD_CLOCK_DELAY_SELECT,
    input wire qsms_pkg::qsms_word_t TX_WORD,
    input wire qsms_pkg::qsms_pcs_t PORT_PIN_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    output qsms_pkg::qsms_word_t RX_WORD,
    output qsms_pkg::qsms_ptr_t RX_INDEX,
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE,
    input wire logic MOSI_IN,
    output logic MOSI_OUT,
    output logic MOSI_OE,
    input wire logic MISO_IN,
    output logic MISO_OUT,
    output logic MISO_OE,
    input wire logic SHARED_SELECT_N_IN,
    output qsms_pkg::qsms_pcs_t PCS_OUT,
    output logic PCS_OE,
    output logic FINISHED_FLAG,
    input wire logic FINISHED_CLR,
    input wire logic FINISHED_INTERRUPT_ENABLE,
    output logic IRQ,
    output logic MODE_FAULT_FLAG,
    input wire logic MODE_FAULT_CLR
);
    import qsms_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_a;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic sck_s, mosi_s, miso_s, ss_n_s, ss_edge;

    assign pin_a = {SCK_IN, MOSI_IN, MISO_IN, SHARED_SELECT_N_IN};
    assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2_r;

    // Third stage only feeds edge detection; select idles high.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            sync1_r <= 4'h1;
            sync2_r <= 4'h1;
            sync3_r <= 4'h1;
        end
        else
        begin
            sync1_r <= pin_a;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ------------------------------------------------------------
    // Decode and selection
    // ------------------------------------------------------------
    qsms_state_e state_r;
    logic [13:0] cnt_r;
    logic [5:0] edge_r;
    logic [4:0] len_r, bit_r;
    logic dt_r, continue_bit_r, ck_r, sck_r;
    logic spe_r, fin_r, irq_r, mode_fault_flag_r, pend_r, reload_r;
    qsms_ptr_t ptr_r, cpt_r;
    qsms_word_t tx_sh_r, rx_sh_r;
    qsms_pcs_t pcs_r;
    logic v0_r, v1_r;
    qsms_word_t d0_r, d1_r;
    qsms_ptr_t i0_r, i1_r;

    logic mst, m_run, slave, slv_act, baud_on, m_cnt_end, m_edge, m_last;
    logic s_edge, edge_w, lead_w, samp_w, drv_w, din_w;
    logic m_done, s_done, done_w, at_end, stop_w, fin_evt;
    logic start_w, busy_w, apply_w, go_w, load_w, pop_w;
    logic [4:0] bits_len, cmd_len, len_use, sh_w;
    logic [13:0] baud_w, lead_dly, trail_dly;
    qsms_ptr_t next_ptr, wrap_ptr;

    assign mst = MASTER_SELECT_BIT;
    assign m_run = spe_r && mst;
    assign slave = spe_r && !mst;
    assign slv_act = slave && !ss_n_s;
    assign bits_len = qsms_len(LENGTH_FIELD);
    assign cmd_len = CMD_LENGTH_SELECT_BIT ? bits_len : LEN_DEFAULT;
    assign len_use = mst ? cmd_len : bits_len;
    assign sh_w = LEN_MAX - len_use;
    assign baud_on = BAUD_DIVISOR >= BAUD_MIN;
    assign baud_w = {6'h00, BAUD_DIVISOR};

    // Lead and trail times; slave mode never reaches these states.
    assign lead_dly = CMD_CLOCK_DELAY_SELECT ? {7'h00, CLOCK_DELAY_COUNT}
                                             : baud_w;
    assign trail_dly = !dt_r ? STD_DELAY_CYC
                     : (AFTER_TRANSFER_DELAY_COUNT == 8'h00) ? DT_ZERO_CYCLES
                     : {1'b0, AFTER_TRANSFER_DELAY_COUNT, 5'h00};

    // Master edges come from the modulus counter, slave edges from the pin.
    assign m_cnt_end = cnt_r <= ONE_CYC;
    assign m_edge = m_run && baud_on && m_cnt_end
                 && (state_r == M_LEAD || state_r == M_SHIFT);
    assign m_last = edge_r == ({len_r, 1'b0} - 6'h01);
    assign s_edge = slv_act && (sck_s != sync3_r[3]);
    assign edge_w = m_edge || s_edge;
    assign lead_w = mst ? !edge_r[0] : (sck_s != CLOCK_POLARITY_BIT);
    assign samp_w = edge_w && (lead_w != CLOCK_PHASE_BIT);
    assign drv_w = edge_w && !samp_w && (bit_r != 5'h00);
    assign din_w = mst ? miso_s : mosi_s;

    // Transfer completion and queue-end test.
    assign m_done = m_run && state_r == M_TRAIL && m_cnt_end;
    assign s_done = slv_act && bit_r == bits_len;
    assign done_w = m_done || s_done;
    assign at_end = ptr_r == END_QUEUE_POINTER;
    assign fin_evt = done_w && at_end;
    assign stop_w = fin_evt && !WRAP_ENABLE_BIT;
    assign wrap_ptr = WRAP_TARGET_BIT ? NEW_QUEUE_POINTER : 4'h0;
    assign next_ptr = !at_end ? ptr_r + 4'h1
                    : WRAP_ENABLE_BIT ? wrap_ptr : ptr_r;

    // A pointer rewrite waits until no transfer is under way.
    assign start_w = PORT_ENABLE_SET && !spe_r;
    assign busy_w = (state_r != M_IDLE) || (bit_r != 5'h00);
    assign apply_w = (NEW_QUEUE_WR || pend_r) && !busy_w && !start_w;
    assign go_w = m_run && !HALT_BIT && !v1_r;
    assign load_w = state_r == M_LOAD || reload_r;
    assign pop_w = v0_r && RX_READY;

    // ------------------------------------------------------------
    // Master sequencer
    // ------------------------------------------------------------
    // Aborts to idle whenever enable drops or the mode changes.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            state_r <= M_IDLE;
            cnt_r <= 14'h0000;
            edge_r <= 6'h00;
            len_r <= LEN_DEFAULT;
            dt_r <= 1'b0;
            continue_bit_r <= 1'b0;
            ck_r <= 1'b0;
        end
        else if (!m_run)
        begin
            state_r <= M_IDLE;
        end
        else
        begin
            unique case (state_r)
                M_IDLE:
                begin
                    if (go_w)
                    begin
                        state_r <= M_LOAD;
                    end
                end
                M_LOAD:
                begin
                    state_r <= M_LEAD;
                    cnt_r <= lead_dly;
                    edge_r <= 6'h00;
                    len_r <= cmd_len;
                    dt_r <= CMD_DELAY_SELECT_BIT;
                    continue_bit_r <= CMD_CONTINUE_BIT;
                    ck_r <= CMD_CLOCK_DELAY_SELECT;
                end
                M_LEAD, M_SHIFT:
                begin
                    if (m_edge)
                    begin
                        edge_r <= edge_r + 6'h01;
                        cnt_r <= (state_r == M_SHIFT && m_last) ? trail_dly : baud_w;
                        if (state_r == M_LEAD)
                        begin
                            state_r <= M_SHIFT;
                        end
                        else if (m_last)
                        begin
                            state_r <= M_TRAIL;
                        end
                    end
                    else if (!m_cnt_end && (baud_on || state_r == M_LEAD))
                    begin
                        cnt_r <= cnt_r - ONE_CYC;
                    end
                end
                M_TRAIL:
                begin
                    if (m_cnt_end)
                    begin
                        state_r <= M_IDLE;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - ONE_CYC;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Slave mode drives only its data output; clock and selects float.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            sck_r <= 1'b0;
            pcs_r <= 4'h0;
            SCK_OE <= 1'b0;
            MISO_OE <= 1'b0;
            HALTED <= 1'b0;
        end
        else
        begin
            SCK_OE <= m_run;
            MISO_OE <= slv_act;
            HALTED <= m_run && HALT_BIT && state_r == M_IDLE;
            if (!m_run || state_r == M_IDLE)
            begin
                sck_r <= CLOCK_POLARITY_BIT;
            end
            else if (m_edge)
            begin
                sck_r <= !sck_r;
            end
            if (!m_run)
            begin
                pcs_r <= PORT_PIN_DATA;
            end
            else if (state_r == M_LOAD)
            begin
                pcs_r <= CMD_CHIP_SELECTS;
            end
            else if (m_done && !continue_bit_r)
            begin
                pcs_r <= PORT_PIN_DATA;
            end
        end
    end

    // ------------------------------------------------------------
    // Shift engine, shared by both modes
    // ------------------------------------------------------------
    // Words leave MSB first; an unsampled first edge never shifts.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            tx_sh_r <= 16'h0000;
            rx_sh_r <= 16'h0000;
            bit_r <= 5'h00;
        end
        else if (load_w)
        begin
            tx_sh_r <= TX_WORD << sh_w;
            rx_sh_r <= 16'h0000;
            bit_r <= 5'h00;
        end
        else if (done_w)
        begin
            bit_r <= 5'h00;
        end
        else
        begin
            if (samp_w)
            begin
                rx_sh_r <= {rx_sh_r[14:0], din_w};
                bit_r <= bit_r + 5'h01;
            end
            if (drv_w)
            begin
                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Queue pointers and port enable
    // ------------------------------------------------------------
    // A slave reloads its word after each word, select change or rewrite.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            ptr_r <= 4'h0;
            cpt_r <= 4'h0;
            pend_r <= 1'b0;
            reload_r <= 1'b0;
            spe_r <= 1'b0;
        end
        else
        begin
            reload_r <= s_done || (slave && ss_edge) || apply_w;
            if (start_w || apply_w)
            begin
                ptr_r <= NEW_QUEUE_POINTER;
                pend_r <= 1'b0;
            end
            else if (done_w)
            begin
                cpt_r <= ptr_r;
                ptr_r <= next_ptr;
                pend_r <= pend_r || NEW_QUEUE_WR;
            end
            else
            begin
                pend_r <= pend_r || NEW_QUEUE_WR;
            end
            if (PORT_ENABLE_SET)
            begin
                spe_r <= 1'b1;
            end
            else if (PORT_ENABLE_CLR || stop_w)
            begin
                spe_r <= 1'b0;
            end
        end
    end
    assign ss_edge = ss_n_s != sync3_r[0];

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Hardware set wins over a clear in the same cycle.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            fin_r <= 1'b0;
            irq_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
        end
        else
        begin
            fin_r <= fin_evt || (fin_r && !FINISHED_CLR);
            irq_r <= (fin_evt && FINISHED_INTERRUPT_ENABLE)
                  || (irq_r && !FINISHED_CLR);
            mode_fault_flag_r <= (mst && !ss_n_s) || (mode_fault_flag_r && !MODE_FAULT_CLR);
        end
    end

    // ------------------------------------------------------------
    // Receive buffer, two entries
    // ------------------------------------------------------------
    // A full buffer stalls the master; a slave cannot wait and drops.
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            d0_r <= 16'h0000;
            d1_r <= 16'h0000;
            i0_r <= 4'h0;
            i1_r <= 4'h0;
        end
        else if (pop_w)
        begin
            v0_r <= v1_r || done_w;
            v1_r <= v1_r && done_w;
            d0_r <= v1_r ? d1_r : rx_sh_r;
            i0_r <= v1_r ? i1_r : ptr_r;
            d1_r <= rx_sh_r;
            i1_r <= ptr_r;
        end
        else if (done_w && !v0_r)
        begin
            v0_r <= 1'b1;
            d0_r <= rx_sh_r;
            i0_r <= ptr_r;
        end
        else if (done_w && !v1_r)
        begin
            v1_r <= 1'b1;
            d1_r <= rx_sh_r;
            i1_r <= ptr_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PORT_ENABLE_BIT = spe_r;
    assign QUEUE_INDEX = ptr_r;
    assign COMPLETED_POINTER = cpt_r;
    assign RX_VALID = v0_r;
    assign RX_WORD = d0_r;
    assign RX_INDEX = i0_r;
    assign SCK_OUT = sck_r;
    assign MOSI_OUT = tx_sh_r[15];
    assign MOSI_OE = SCK_OE;
    assign MISO_OUT = tx_sh_r[15];
    assign PCS_OUT = pcs_r;
    assign PCS_OE = SCK_OE;
    assign FINISHED_FLAG = fin_r;
    assign IRQ = irq_r;
    assign MODE_FAULT_FLAG = mode_fault_flag_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    qsms_state_e last_r;
    logic [13:0] stay_r;
    logic [13:0] stay_w;

    // Cycles spent in the current master state, the present cycle included.
    assign stay_w = (state_r != last_r) ? ONE_CYC : stay_r + ONE_CYC;
    always_ff @(posedge MCLK)
    begin
        last_r <= state_r;
        stay_r <= stay_w;
    end

    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence s_queue_end;
        done_w && at_end;
    endsequence

    a_mode_fault_set: assert property (mst && !ss_n_s |=> mode_fault_flag_r)
        else $error("mode fault not raised");
    a_sck_stays_put: assert property (m_run && !baud_on && state_r == M_SHIFT ##1
        !baud_on |-> $stable(sck_r))
        else $error("clock moved with divisor off");
    a_lead_delay_cnt: assert property (state_r == M_LEAD && m_edge && ck_r
        && CLOCK_DELAY_COUNT != 7'h00 |-> stay_w == {7'h00, CLOCK_DELAY_COUNT})
        else $error("lead delay wrong");
    a_trail_scaled: assert property (m_done && dt_r && AFTER_TRANSFER_DELAY_COUNT != 8'h00
        |-> stay_w == {1'b0, AFTER_TRANSFER_DELAY_COUNT, 5'h00})
        else $error("scaled trail delay wrong");
    a_trail_zero: assert property (m_done && dt_r && AFTER_TRANSFER_DELAY_COUNT == 8'h00
        |-> stay_w == DT_ZERO_CYCLES)
        else $error("zero-count trail delay wrong");
    a_trail_standard: assert property (m_done && !dt_r |-> stay_w == STD_DELAY_CYC)
        else $error("standard trail delay wrong");
    a_pointer_step: assert property (done_w && !at_end |=> cpt_r == $past(ptr_r)
        && ptr_r == $past(ptr_r) + 4'h1)
        else $error("pointer did not step");
    a_queue_stops: assert property (s_queue_end ##0 !WRAP_ENABLE_BIT && !PORT_ENABLE_SET
        |=> !spe_r && fin_r)
        else $error("queue end did not stop");
    a_wrap_runs: assert property (s_queue_end ##0 WRAP_ENABLE_BIT && spe_r
        && !PORT_ENABLE_CLR |=> spe_r && fin_r)
        else $error("wrap did not keep running");
    a_irq_buffered: assert property (irq_r && !FINISHED_CLR |=> irq_r)
        else $error("request withdrawn without flag clear");

endmodule : qsms_top

`default_nettype wire

// File: testbench/qsms_peer.sv
// Peripheral on the far side of the serial port, clock mode zero.
// Assumes one active-high chip select and a left-justified word to send.
`timescale 1ns/100ps
`default_nettype none
module qsms_peer (
    input wire logic sck,
    input wire logic cs_act,
    input wire logic mosi,
    output logic miso,
    input wire logic [15:0] tx,
    output logic [15:0] rx
);
    logic [15:0] sh;
    // Each select reloads the word, so a dropped select restarts it.
    always @(posedge cs_act)
    begin
        sh = tx;
        rx = 16'h0000;
    end
    // Sample on the rising edge, shift on the falling edge, MSB first.
    always @(posedge sck) rx = {rx[14:0], mosi};
    always @(negedge sck) sh = sh << 1;
    // The line has a pull-up, so a deselected peer reads as one.
    assign miso = cs_act ? sh[15] : 1'b1;
endmodule : qsms_peer
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the queued serial port in both modes.
// Assumes the peer model and an array standing in for queue storage.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import qsms_pkg::*;
    logic MCLK, RESET_N, MASTER_SELECT_BIT, PORT_ENABLE_SET, PORT_ENABLE_CLR, HALT_BIT;
    logic CLOCK_PHASE_BIT, CLOCK_POLARITY_BIT, WRAP_ENABLE_BIT, WRAP_TARGET_BIT, NEW_QUEUE_WR;
    logic CMD_CONTINUE_BIT, CMD_LENGTH_SELECT_BIT, CMD_DELAY_SELECT_BIT, CMD_CLOCK_DELAY_SELECT;
    logic RX_READY, SCK_IN, MOSI_IN, MISO_IN, SHARED_SELECT_N_IN, FINISHED_CLR, MODE_FAULT_CLR;
    logic FINISHED_INTERRUPT_ENABLE, PORT_ENABLE_BIT, HALTED, RX_VALID, SCK_OUT, SCK_OE;
    logic MOSI_OUT, MOSI_OE, MISO_OUT, MISO_OE, PCS_OE, FINISHED_FLAG, IRQ, MODE_FAULT_FLAG;
    logic [7:0] BAUD_DIVISOR, AFTER_TRANSFER_DELAY_COUNT;
    logic [6:0] CLOCK_DELAY_COUNT;
    logic [3:0] LENGTH_FIELD;
    qsms_ptr_t NEW_QUEUE_POINTER, END_QUEUE_POINTER, QUEUE_INDEX, COMPLETED_POINTER, RX_INDEX;
    qsms_pcs_t CMD_CHIP_SELECTS, PORT_PIN_DATA, PCS_OUT;
    qsms_word_t TX_WORD, RX_WORD, ptx, prx;
    qsms_word_t txm [16];
    int checks, err_total, hc, hp;
    logic sck_d;
    logic [7:0] sm, sb;

    qsms_top #(.DT_ZERO_CYCLES(14'h0040)) dut_u (.*);
    qsms_peer peer_u (.sck(SCK_OUT), .cs_act(PCS_OE & PCS_OUT[0]), .mosi(MOSI_OUT),
        .miso(MISO_IN), .tx(ptx), .rx(prx));
    // Queue storage answers in the same cycle as the index.
    assign TX_WORD = txm[QUEUE_INDEX];

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // Half period of the serial clock, in system clocks, from its last edge.
    always @(posedge MCLK)
    begin
        sck_d <= SCK_OUT;
        hc <= hc + 1;
        if (SCK_OUT !== sck_d)
        begin
            hp <= hc;
            hc <= 1;
        end
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // A pulse lasts one full cycle, launched and dropped on falling edges.
    task automatic go(ref logic p);
        @(negedge MCLK) p = 1'b1;
        @(negedge MCLK) p = 1'b0;
    endtask : go

    task automatic wfin();
        repeat (4000) if (FINISHED_FLAG !== 1'b1) @(negedge MCLK);
        repeat (2) @(negedge MCLK);
    endtask : wfin

    task automatic pop(input logic [15:0] w, input logic [3:0] i);
        chk("rx_valid", RX_VALID, 1'b1);
        chk("rx_word", RX_WORD, w);
        chk("rx_index", RX_INDEX, i);
        go(RX_READY);
    endtask : pop

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // A hang is cut short well after the five tests should have ended.
    initial
    begin
        #200000;
        err_total++;
        $display("BAD watchdog expected done seen hang");
        summarize();
    end

    initial
    begin
        {PORT_ENABLE_SET, PORT_ENABLE_CLR, HALT_BIT, CLOCK_PHASE_BIT, CLOCK_POLARITY_BIT} = '0;
        {WRAP_ENABLE_BIT, WRAP_TARGET_BIT, NEW_QUEUE_WR, CMD_CONTINUE_BIT, RX_READY} = '0;
        {CMD_LENGTH_SELECT_BIT, CMD_DELAY_SELECT_BIT, CMD_CLOCK_DELAY_SELECT, SCK_IN} = '0;
        {MOSI_IN, FINISHED_CLR, MODE_FAULT_CLR, RESET_N, NEW_QUEUE_POINTER} = '0;
        {END_QUEUE_POINTER, CLOCK_DELAY_COUNT, AFTER_TRANSFER_DELAY_COUNT, LENGTH_FIELD} = '0;
        {MASTER_SELECT_BIT, SHARED_SELECT_N_IN, FINISHED_INTERRUPT_ENABLE} = 3'b111;
        {BAUD_DIVISOR, CMD_CHIP_SELECTS, PORT_PIN_DATA} = {8'h04, 4'h1, 4'h0};
        {ptx, txm[0], txm[1]} = {16'ha5c3, 16'h005a, 16'habcd};
        repeat (12) @(negedge MCLK);
        RESET_N = 1'b1;
        // Pointers left at zero give one eight-bit transfer, then a stop.
        go(PORT_ENABLE_SET);
        wfin();
        chk("enable", PORT_ENABLE_BIT, 1'b0);
        chk("irq", IRQ, 1'b1);
        chk("completed", COMPLETED_POINTER, 4'h0);
        chk("half_period", hp[15:0], 16'h0004);
        chk("sck_idle", SCK_OUT, 1'b0);
        chk("pcs_between", PCS_OUT, 4'h0);
        chk("peer_rx", prx[7:0], 8'h5a);
        pop(16'h00a5, 4'h0);
        go(FINISHED_CLR);
        chk("irq_clear", IRQ, 1'b0);
        $display("test single transfer done");
        // Two sixteen-bit entries back to back at a slower serial clock.
        {END_QUEUE_POINTER, CMD_LENGTH_SELECT_BIT, BAUD_DIVISOR, ptx} = {4'h1, 1'b1, 8'h05, 16'h3c96};
        txm[0] = 16'h1234;
        go(PORT_ENABLE_SET);
        wfin();
        chk("completed", COMPLETED_POINTER, 4'h1);
        chk("half_period", hp[15:0], 16'h0005);
        chk("peer_rx", prx, 16'habcd);
        pop(16'h3c96, 4'h0);
        pop(16'h3c96, 4'h1);
        go(FINISHED_CLR);
        $display("test two entries done");
        // Wrapped queue with held selects, timed delays and fifteen-bit words.
        {WRAP_ENABLE_BIT, CMD_CONTINUE_BIT, CMD_CLOCK_DELAY_SELECT, CMD_DELAY_SELECT_BIT} = 4'hf;
        {CLOCK_DELAY_COUNT, AFTER_TRANSFER_DELAY_COUNT, LENGTH_FIELD} = {7'h03, 8'h01, 4'hf};
        go(PORT_ENABLE_SET);
        wfin();
        chk("wrap_enable", PORT_ENABLE_BIT, 1'b1);
        chk("pcs_held", PCS_OUT, 4'h1);
        chk("wrap_index", QUEUE_INDEX, 4'h0);
        {WRAP_ENABLE_BIT, HALT_BIT, AFTER_TRANSFER_DELAY_COUNT} = {1'b0, 1'b1, 8'h00};
        pop(16'h1e4b, 4'h0);
        pop(16'h0000, 4'h1);
        chk("halted", HALTED, 1'b1);
        HALT_BIT = 1'b0;
        go(FINISHED_CLR);
        wfin();
        chk("wrap_off_stop", PORT_ENABLE_BIT, 1'b0);
        chk("peer_rx", prx, 16'h2bcd);
        pop(16'h0000, 4'h0);
        pop(16'h0000, 4'h1);
        go(FINISHED_CLR);
        $display("test wrap and halt done");
        // A low select while master raises the fault flag until cleared.
        SHARED_SELECT_N_IN = 1'b0;
        repeat (4) @(negedge MCLK);
        SHARED_SELECT_N_IN = 1'b1;
        repeat (4) @(negedge MCLK);
        chk("mode_fault", MODE_FAULT_FLAG, 1'b1);
        go(MODE_FAULT_CLR);
        chk("mode_fault_clr", MODE_FAULT_FLAG, 1'b0);
        // A divisor of one freezes the serial clock; clearing enable aborts.
        BAUD_DIVISOR = 8'h01;
        go(PORT_ENABLE_SET);
        repeat (40) @(negedge MCLK);
        chk("sck_frozen", hc > 40, 1'b1);
        go(PORT_ENABLE_CLR);
        chk("aborted", PORT_ENABLE_BIT, 1'b0);
        $display("test mode fault done");
        // Slave mode: an external master clocks one eight-bit word in mode zero.
        {MASTER_SELECT_BIT, LENGTH_FIELD, END_QUEUE_POINTER, sb} = {1'b0, 4'h8, 4'h0, 8'hc5};
        go(PORT_ENABLE_SET);
        SHARED_SELECT_N_IN = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            MOSI_IN = sb[i];
            repeat (8) @(negedge MCLK);
            SCK_IN = 1'b1;
            sm = {sm[6:0], MISO_OUT};
            repeat (8) @(negedge MCLK);
            SCK_IN = 1'b0;
        end
        SHARED_SELECT_N_IN = 1'b1;
        chk("slave_miso", sm, 8'h34);
        chk("slave_sck_oe", SCK_OE, 1'b0);
        chk("slave_end", FINISHED_FLAG, 1'b1);
        pop(16'h00c5, 4'h0);
        $display("test slave word done");
        summarize();
    end
endmodule : tb
`default_nettype wire
